// File: src/cidp_cfg.svh
// Contract
// - index write to 22h selects a config register; data then moves through 23h
// - accesses reaching an on-chip register complete inside, no external cycle
// - data-port access without a valid index goes external, registers untouched
// - index writes outside C0h-CFh and FEh-FFh go external, keep the selection and disarm any armed index
// - reads of the index port always go external
// - decode a 64 KB I/O space, 8-, 16- and 32-bit accesses
// - upper range 800000F8h-800000FFh is not reserved, treated as any address
// - with trapping enabled, accesses to 3B0h-3DFh raise an SMI
`ifndef CIDP_CFG_SVH
`define CIDP_CFG_SVH
`define CIDP_PORT_INDEX    16'h0022
`define CIDP_PORT_DATA     16'h0023
`define CIDP_IO_TOP        32'h0000ffff
`define CIDP_IDX_LO_MIN    8'hc0
`define CIDP_IDX_LO_MAX    8'hcf
`define CIDP_IDX_HI_MIN    8'hfe
`define CIDP_IDX_HI_MAX    8'hff
`define CIDP_TRAP_LO       16'h03b0
`define CIDP_TRAP_HI       16'h03df
`define CIDP_TRAP_B_LO     16'h03b0
`define CIDP_TRAP_B_HI     16'h03bf
`define CIDP_TRAP_C_LO     16'h03c0
`define CIDP_TRAP_C_HI     16'h03cf
`define CIDP_TRAP_D_LO     16'h03d0
`define CIDP_TRAP_D_HI     16'h03df
`define CIDP_MAP_RESET     8'h00
`define CIDP_BIT_TRAP_B    0
`define CIDP_BIT_TRAP_C    1
`define CIDP_BIT_TRAP_D    2
`define CIDP_IDX_MAP       8'hc0
`endif

// File: src/cidp_pkg.sv
package cidp_pkg;
	typedef enum logic [1:0] {
		CIDP_SZ_8  = 2'h0,
		CIDP_SZ_16 = 2'h1,
		CIDP_SZ_32 = 2'h2
	} cidp_size_t;
	typedef struct packed {
		logic        write;
		logic [31:0] addr;
		cidp_size_t  size;
		logic [31:0] wdata;
	} cidp_req_t;
	typedef enum logic [1:0] {
		CIDP_ST_IDLE = 2'b00,
		CIDP_ST_INT  = 2'b11,
		CIDP_ST_EXT  = 2'b01
	} cidp_state_t;
endpackage

// File: src/cidp_index_check.sv
`timescale 1ns/1ns
`default_nettype none
`include "cidp_cfg.svh"
module cidp_index_check (
	input  wire logic [7:0] index,   // candidate index byte
	output logic            valid    // index in on-chip range
);
	// both ranges accepted by the core
	always_comb begin
		valid = ((index >= `CIDP_IDX_LO_MIN) && (index <= `CIDP_IDX_LO_MAX)) ||
			((index >= `CIDP_IDX_HI_MIN) && (index <= `CIDP_IDX_HI_MAX));
	end
endmodule // cidp_index_check
`default_nettype wire

// File: src/cidp_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "cidp_cfg.svh"
module cidp_decode #(
	parameter int NREG = 18                          // on-chip config registers
) (
	input  wire logic              clock,             // core clock
	input  wire logic              rst_n,             // async reset, active low
	input  wire logic              req_valid,         // core IN/OUT request
	input  wire cidp_pkg::cidp_req_t req,             // request contents
	output logic                   req_ready,         // request accepted
	output logic                   rsp_valid,         // answer pulse, for internal and external completions
	output logic [31:0]            rsp_rdata,         // read data, internal or from ext_rdata
	output logic                   ext_valid,         // external cycle request
	output cidp_pkg::cidp_req_t    ext_req,           // external cycle contents
	input  wire logic              ext_done,          // external cycle finished
	input  wire logic [31:0]       ext_rdata,         // external read data
	output logic                   smi_trap,          // smi request pulse
	output logic [7:0]             trap_map           // trap map register view
);
	cidp_pkg::cidp_state_t state_reg, state_next;
	cidp_pkg::cidp_req_t   ext_reg, ext_next;
	logic [7:0]  sel_reg, sel_next;
	logic        idx_ok_reg, idx_ok_next;
	logic        rsp_reg, rsp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        smi_reg, smi_next;
	logic [7:0]  cfg_reg [NREG];
	logic [7:0]  cfg_next [NREG];
	logic        wr_ok;
	logic        in_space, is_idx, is_dat, in_trap;
	logic [15:0] a16;
	logic [4:0]  slot;

	cidp_index_check cidp_index_check_i (
		.index (req.wdata[7:0]),
		.valid (wr_ok)
	);

	// decode of the 64 KB space; upper addresses are not special
	always_comb begin
		in_space = (req.addr <= `CIDP_IO_TOP);
		a16      = req.addr[15:0];
		is_idx   = in_space && (a16 == `CIDP_PORT_INDEX);
		is_dat   = in_space && (a16 == `CIDP_PORT_DATA);
		in_trap  = in_space &&
			((cfg_reg[0][`CIDP_BIT_TRAP_B] && a16 >= `CIDP_TRAP_B_LO && a16 <= `CIDP_TRAP_B_HI) ||
			 (cfg_reg[0][`CIDP_BIT_TRAP_C] && a16 >= `CIDP_TRAP_C_LO && a16 <= `CIDP_TRAP_C_HI) ||
			 (cfg_reg[0][`CIDP_BIT_TRAP_D] && a16 >= `CIDP_TRAP_D_LO && a16 <= `CIDP_TRAP_D_HI));
		// index c0..cf map to 0..15, fe..ff to 16..17
		if (sel_reg[7:4] == 4'hc)
			slot = {1'b0, sel_reg[3:0]};
		else
			slot = 5'h10 + {4'h0, sel_reg[0]};
	end

	assign req_ready = (state_reg == cidp_pkg::CIDP_ST_IDLE);
	assign rsp_valid = rsp_reg;
	assign rsp_rdata = rdata_reg;
	assign ext_valid = (state_reg == cidp_pkg::CIDP_ST_EXT);
	assign ext_req   = ext_reg;
	assign smi_trap  = smi_reg;
	assign trap_map  = cfg_reg[0];

	// one request at a time; external cycles hold the core until done
	always_comb begin
		state_next  = state_reg;
		ext_next    = ext_reg;
		sel_next    = sel_reg;
		idx_ok_next = idx_ok_reg;
		rsp_next    = 1'b0;
		rdata_next  = rdata_reg;
		smi_next    = 1'b0;
		for (int i = 0; i < NREG; i++)
			cfg_next[i] = cfg_reg[i];
		case (state_reg)
			cidp_pkg::CIDP_ST_IDLE: begin
				if (req_valid) begin
					smi_next = in_trap;
					if (is_idx && req.write && wr_ok) begin
						sel_next    = req.wdata[7:0];
						idx_ok_next = 1'b1;
						rsp_next    = 1'b1;
					end else if (is_dat && idx_ok_reg) begin
						idx_ok_next = 1'b0;
						rsp_next    = 1'b1;
						if (req.write)
							cfg_next[slot] = req.wdata[7:0];
						else
							rdata_next = {24'h0, cfg_reg[slot]};
					end else begin
						// bad index, index read, unindexed data, all else
						if (is_dat)
							idx_ok_next = 1'b0;
						// a rejected index must not leave an older index armed
						if (is_idx && req.write)
							idx_ok_next = 1'b0;
						if (is_idx && !req.write)
							idx_ok_next = idx_ok_reg;
						ext_next   = req;
						state_next = cidp_pkg::CIDP_ST_EXT;
					end
				end
			end
			cidp_pkg::CIDP_ST_EXT: begin
				if (ext_done) begin
					rsp_next   = 1'b1;
					rdata_next = ext_rdata;
					state_next = cidp_pkg::CIDP_ST_INT;
				end
			end
			cidp_pkg::CIDP_ST_INT: state_next = cidp_pkg::CIDP_ST_IDLE;
			default: state_next = cidp_pkg::CIDP_ST_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg  <= cidp_pkg::CIDP_ST_IDLE;
			ext_reg    <= '0;
			sel_reg    <= 8'h00;
			idx_ok_reg <= 1'b0;
			rsp_reg    <= 1'b0;
			rdata_reg  <= 32'h0;
			smi_reg    <= 1'b0;
			for (int i = 0; i < NREG; i++)
				cfg_reg[i] <= `CIDP_MAP_RESET;
		end else begin
			state_reg  <= state_next;
			ext_reg    <= ext_next;
			sel_reg    <= sel_next;
			idx_ok_reg <= idx_ok_next;
			rsp_reg    <= rsp_next;
			rdata_reg  <= rdata_next;
			smi_reg    <= smi_next;
			for (int i = 0; i < NREG; i++)
				cfg_reg[i] <= cfg_next[i];
		end
	end

	// internal completions never start an external cycle
	a_int_no_ext: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_idx && req.write && wr_ok) |=> !ext_valid)
		else $error("index write went external");
	a_bad_idx_ext: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_idx && req.write && !wr_ok)
		|=> ext_valid && $stable(sel_reg) && !idx_ok_reg)
		else $error("bad index not forwarded");
	a_idx_read_ext: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_idx && !req.write) |=> ext_valid)
		else $error("index read not forwarded");
	a_unidx_ext: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_dat && !idx_ok_reg) |=> ext_valid && !idx_ok_reg)
		else $error("unindexed data access handled inside");
	a_idx_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_dat) |=> !idx_ok_reg)
		else $error("index state not cleared");
	a_data_int: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_dat && idx_ok_reg) |=> rsp_valid && !ext_valid)
		else $error("indexed data access not internal");
	a_trap_smi: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && in_trap) |=> smi_trap)
		else $error("trap missed");
	a_no_trap: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && !in_trap) |=> !smi_trap)
		else $error("spurious smi");
	a_out_space: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && !in_space) |=> ext_valid)
		else $error("out of space access not forwarded");
	a_ext_done: assert property (@(posedge clock) disable iff (!rst_n)
		(ext_valid && ext_done) |=> rsp_valid ##1 req_ready)
		else $error("external completion lost");

	// selection and storage change only through an accepted index or data access
	a_idx_set: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_idx && req.write && wr_ok)
		|=> idx_ok_reg && (sel_reg == $past(req.wdata[7:0])))
		else $error("valid index not taken");
	a_sel_keep: assert property (@(posedge clock) disable iff (!rst_n)
		!(req_valid && req_ready && is_idx && req.write && wr_ok) |=> $stable(sel_reg))
		else $error("selection moved without a valid index");
	a_cfg_write: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_dat && idx_ok_reg && req.write && slot == 5'h00)
		|=> trap_map == $past(req.wdata[7:0]))
		else $error("trap map write lost");
	a_cfg_read: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_dat && idx_ok_reg && !req.write && slot == 5'h00)
		|=> rsp_rdata == {24'h00, $past(trap_map)})
		else $error("trap map read wrong");
	a_unidx_keep: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_dat && !idx_ok_reg) |=> $stable(trap_map))
		else $error("unindexed access changed the trap map");
	a_idx_read_keep: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_idx && !req.write) |=> $stable(idx_ok_reg))
		else $error("index read changed index state");

	// forwarded cycles carry the request unchanged and return the far side's data
	a_ext_fwd: assert property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_dat && !idx_ok_reg) |=> ext_req == $past(req))
		else $error("forwarded request altered");
	a_ext_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(ext_valid && !ext_done) |=> ext_valid && $stable(ext_req))
		else $error("external cycle dropped early");
	a_ext_rdata: assert property (@(posedge clock) disable iff (!rst_n)
		(ext_valid && ext_done) |=> rsp_rdata == $past(ext_rdata))
		else $error("external read data lost");
	a_smi_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		smi_trap |=> !smi_trap)
		else $error("smi held too long");

	// main scenarios seen

	c_idx_then_data: cover property (@(posedge clock) disable iff (!rst_n)
		(req_valid && req_ready && is_idx && req.write && wr_ok) ##[1:4]
		(req_valid && req_ready && is_dat));
	c_ext_cycle: cover property (@(posedge clock) disable iff (!rst_n)
		ext_valid ##[1:8] ext_done);
	c_trap: cover property (@(posedge clock) disable iff (!rst_n) smi_trap);
	c_bad_idx: cover property (@(posedge clock) disable iff (!rst_n)
		req_valid && req_ready && is_idx && req.write && !wr_ok);
	c_idx_read: cover property (@(posedge clock) disable iff (!rst_n)
		req_valid && req_ready && is_idx && !req.write);
endmodule // cidp_decode
`default_nettype wire

// File: verification/cidp_io_partner.sv
`timescale 1ns/1ns
`default_nettype none
module cidp_io_partner (
	input  wire logic                clock,     // core clock
	input  wire logic                rst_n,     // async reset
	input  wire logic [3:0]          lag,       // wait states
	input  wire logic                ext_valid, // cycle pending
	input  wire cidp_pkg::cidp_req_t ext_req,   // cycle contents
	output logic                     ext_done,  // cycle finished
	output logic [31:0]              ext_rdata  // read data
);
	logic [3:0] cnt_reg;
	// answer after lag cycles; data toggles otherwise so a stale value never matches
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_done <= 1'b0;
			ext_rdata <= 32'h0;
			cnt_reg <= 4'h0;
		end else begin
			ext_done <= 1'b0;
			ext_rdata <= ~ext_rdata;
			if (ext_valid && !ext_done && cnt_reg == lag) begin
				ext_done <= 1'b1;
				ext_rdata <= {16'ha5a5, ext_req.addr[15:0]};
				cnt_reg <= 4'h0;
			end else if (ext_valid && !ext_done) begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end
endmodule // cidp_io_partner
`default_nettype wire

// File: verification/config_index_data_port_decode_tb.sv
`timescale 1ns/1ns
`default_nettype none
module config_index_data_port_decode_tb;
	logic                clock = 0;
	logic                rst_n = 0;
	logic                req_valid = 0;
	cidp_pkg::cidp_req_t req = '0;
	logic                req_ready, rsp_valid, ext_valid, ext_done, smi_trap;
	logic [31:0]         rsp_rdata, ext_rdata, rd;
	cidp_pkg::cidp_req_t ext_req;
	logic [7:0]          trap_map;
	logic [3:0]          lag = 4'h0;
	int                  fails = 0;
	int                  n_checks = 0;
	always #5 clock = ~clock;
	cidp_decode cidp_decode_i (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.ext_valid(ext_valid), .ext_req(ext_req), .ext_done(ext_done), .ext_rdata(ext_rdata),
		.smi_trap(smi_trap), .trap_map(trap_map));
	cidp_io_partner cidp_io_partner_i (.clock(clock), .rst_n(rst_n), .lag(lag),
		.ext_valid(ext_valid), .ext_req(ext_req), .ext_done(ext_done), .ext_rdata(ext_rdata));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one core access; samples at negedge so edge updates have landed
	task automatic io(input logic w, input logic [31:0] a, input cidp_pkg::cidp_size_t sz,
		input logic [31:0] d, input logic ext, input logic smi);
		logic                se, sm, done;
		cidp_pkg::cidp_req_t er;
		se = 1'h0;
		sm = 1'h0;
		done = 1'h0;
		for (int n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clock);
		@(posedge clock);
		req_valid <= 1'b1;
		req <= '{write: w, addr: a, size: sz, wdata: d};
		@(posedge clock);
		req_valid <= 1'b0;
		for (int n = 0; n < 40 && !done; n++) begin
			@(negedge clock);
			se |= (ext_valid === 1'b1);
			sm |= (smi_trap === 1'b1);
			if (ext_valid === 1'b1)
				er = ext_req;
			done = (rsp_valid === 1'b1);
		end
		rd = rsp_rdata;
		chk("answer", 32'h1, {31'h0, done});
		chk("external", {31'h0, ext}, {31'h0, se});
		chk("smi", {31'h0, smi}, {31'h0, sm});
		if (ext) begin
			chk("ext addr", a, er.addr);
			chk("ext wdata", d, er.wdata);
			chk("ext kind", {29'h0, w, sz}, {29'h0, er.write, er.size});
		end
	endtask
	task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
		io(1'h1, 32'h22, cidp_pkg::CIDP_SZ_8, {24'h0, idx}, 1'h0, 1'h0);
		io(1'h1, 32'h23, cidp_pkg::CIDP_SZ_8, {24'h0, d}, 1'h0, 1'h0);
	endtask
	// trap map and index state start cleared
	task automatic sc_reset_state;
		chk("map reset", 32'h0, {24'h0, trap_map});
		io(1'h0, 32'h23, cidp_pkg::CIDP_SZ_8, 32'h0, 1'h1, 1'h0);
	endtask
	// index write then one data access, both held inside
	task automatic sc_cfg_access;
		cfg(8'hc0, 8'h07);
		chk("map", 32'h7, {24'h0, trap_map});
		cfg(8'hfe, 8'haa);
		io(1'h1, 32'h22, cidp_pkg::CIDP_SZ_8, 32'hfe, 1'h0, 1'h0);
		io(1'h0, 32'h23, cidp_pkg::CIDP_SZ_8, 32'h0, 1'h0, 1'h0);
		chk("cfg read", 32'haa, {24'h0, rd[7:0]});
	endtask
	// data access without a fresh valid index leaves the chip, with wait states
	task automatic sc_unindexed;
		@(posedge clock);
		lag <= 4'h5;
		io(1'h0, 32'h23, cidp_pkg::CIDP_SZ_8, 32'h0, 1'h1, 1'h0);
		chk("ext read", 32'ha5a50023, rd);
		io(1'h1, 32'h22, cidp_pkg::CIDP_SZ_8, 32'hc0, 1'h0, 1'h0);
		io(1'h1, 32'h22, cidp_pkg::CIDP_SZ_8, 32'hd0, 1'h1, 1'h0);
		io(1'h1, 32'h23, cidp_pkg::CIDP_SZ_8, 32'h55, 1'h1, 1'h0);
		chk("map kept", 32'h7, {24'h0, trap_map});
	endtask
	// an index read goes out and leaves the armed index alone
	task automatic sc_index_read;
		io(1'h1, 32'h22, cidp_pkg::CIDP_SZ_8, 32'hc0, 1'h0, 1'h0);
		io(1'h0, 32'h22, cidp_pkg::CIDP_SZ_8, 32'h0, 1'h1, 1'h0);
		io(1'h0, 32'h23, cidp_pkg::CIDP_SZ_8, 32'h0, 1'h0, 1'h0);
		chk("read after index read", 32'h7, {24'h0, rd[7:0]});
	endtask
	// each display sub-range traps while its map bit is set
	task automatic sc_trap;
		@(posedge clock);
		lag <= 4'h0;
		io(1'h1, 32'h3b0, cidp_pkg::CIDP_SZ_16, 32'h1, 1'h1, 1'h1);
		io(1'h1, 32'h3c5, cidp_pkg::CIDP_SZ_8, 32'h1, 1'h1, 1'h1);
		io(1'h1, 32'h3df, cidp_pkg::CIDP_SZ_8, 32'h1, 1'h1, 1'h1);
		io(1'h1, 32'h3e0, cidp_pkg::CIDP_SZ_8, 32'h1, 1'h1, 1'h0);
	endtask
	// top of the 64 KB space and the old coprocessor range go out as plain cycles
	task automatic sc_space;
		io(1'h0, 32'h800000f8, cidp_pkg::CIDP_SZ_8, 32'h0, 1'h1, 1'h0);
		io(1'h0, 32'hffff, cidp_pkg::CIDP_SZ_32, 32'h0, 1'h1, 1'h0);
		chk("ext top", 32'ha5a5ffff, rd);
	endtask
	// reset in mid-run disarms the index and clears the trap map
	task automatic sc_mid_reset;
		io(1'h1, 32'h22, cidp_pkg::CIDP_SZ_8, 32'hc0, 1'h0, 1'h0);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk("map after reset", 32'h0, {24'h0, trap_map});
		io(1'h1, 32'h23, cidp_pkg::CIDP_SZ_8, 32'h55, 1'h1, 1'h0);
		io(1'h1, 32'h3d0, cidp_pkg::CIDP_SZ_8, 32'h1, 1'h1, 1'h0);
		chk("map after unindexed", 32'h0, {24'h0, trap_map});
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// cut a hang short
	initial begin
		repeat (5000) @(posedge clock);
		fails++;
		print_verdict;
	end
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		sc_reset_state;
		sc_cfg_access;
		sc_unindexed;
		sc_index_read;
		sc_trap;
		sc_space;
		sc_mid_reset;
		print_verdict;
	end
endmodule // config_index_data_port_decode_tb
`default_nettype wire
